// File: rtl/base_clock_pkg.sv
package base_clock_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] SEL1_IDX  = 16'hFF39;
	localparam logic [15:0] SEL0_IDX  = 16'hFF56;
	localparam logic [15:0] CTRL0_IDX = 16'hFF60;
	localparam logic [15:0] CTRL1_IDX = 16'hFF61;
	localparam logic [15:0] DIV0_IDX  = 16'hFF62;
	localparam logic [15:0] DIV1_IDX  = 16'hFF63;
	localparam logic [15:0] STAT_IDX  = 16'hFF64;

	localparam int          ADDR_W    = 18;
	localparam logic [17:0] SEL0_ADDR  = {SEL0_IDX, 2'b00};
	localparam logic [17:0] SEL1_ADDR  = {SEL1_IDX, 2'b00};
	localparam logic [17:0] CTRL0_ADDR = {CTRL0_IDX, 2'b00};
	localparam logic [17:0] CTRL1_ADDR = {CTRL1_IDX, 2'b00};
	localparam logic [17:0] DIV0_ADDR  = {DIV0_IDX, 2'b00};
	localparam logic [17:0] DIV1_ADDR  = {DIV1_IDX, 2'b00};
	localparam logic [17:0] STAT_ADDR  = {STAT_IDX, 2'b00};

	// reset values
	localparam logic [3:0] SEL_RESET  = 4'h0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET  = 8'hFF;

	// field positions
	localparam int SEL_LSB   = 0;
	localparam int SEL_W     = 4;
	localparam int POWER_BIT = 7;
	localparam int TXE_BIT   = 6;
	localparam int RXE_BIT   = 5;

	// selection codes and counts
	localparam logic [3:0] CODE_MAX_DIV = 4'hA;
	localparam logic [3:0] CODE_TIMER   = 4'hB;
	localparam int         PRESCALE_W   = 10;
	localparam logic [7:0] DIV_MIN      = 8'h04;

	typedef struct packed {
		logic power;
		logic txe;
		logic rxe;
	} unit_ctrl_t;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_t;

endpackage

// File: rtl/pow2_prescaler.sv
`timescale 1ns/1ns
module pow2_prescaler #(
	parameter int STAGES = base_clock_pkg::PRESCALE_W
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// prescaler state
	output logic [STAGES-1:0]      count,
	output logic [STAGES:0]        tick
);
	logic [STAGES-1:0] count_reg;

	// free running; never restarted by register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + 1'b1;
		end
	end

	assign count   = count_reg;
	assign tick[0] = 1'b1;

	// stage c fires once every 2^c cycles
	for (genvar c = 1; c <= STAGES; c++) begin : g_tick
		assign tick[c] = &count_reg[c-1:0];
	end
endmodule // pow2_prescaler

// File: rtl/baud_counter.sv
`timescale 1ns/1ns
module baud_counter (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic       enable,
	input  wire logic       base_tick,
	input  wire logic [7:0] divisor,
	// outputs
	output logic            counter_pulse,
	output logic            baud_clk
);
	logic [7:0] cnt_reg;
	logic [7:0] limit;
	logic       pulse_reg;
	logic       baud_reg;

	// codes below four are prohibited; treat them as four
	assign limit = (divisor < base_clock_pkg::DIV_MIN) ? base_clock_pkg::DIV_MIN : divisor;

	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			cnt_reg   <= 8'h00;
			pulse_reg <= 1'b0;
			baud_reg  <= 1'b0;
		end else if (base_tick && cnt_reg == limit - 8'h01) begin
			cnt_reg   <= 8'h00;
			pulse_reg <= 1'b1;
			baud_reg  <= ~baud_reg;
		end else begin
			cnt_reg   <= base_tick ? cnt_reg + 8'h01 : cnt_reg;
			pulse_reg <= 1'b0;
		end
	end

	assign counter_pulse = pulse_reg;
	assign baud_clk      = baud_reg;
endmodule // baud_counter

// File: rtl/base_clock_select.sv
// What this block does
// - reset clears both select registers to zero, choosing the undivided clock.
// - same-value rewrite while a unit communicates leaves its clocks undisturbed.
// - select field is bits 3..0; bits 7..4 read zero.
// - codes 0..10 pick clock over 2^code; 11 picks timer; others prohibited.
// - timer output reaches the base clock internally, pin enable irrelevant.
// - baud rate is the baud counter output divided by two.
`timescale 1ns/1ns
module base_clock_select (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// apb slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [17:0]                    paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	// companion timer
	input  wire logic                           timer_out,
	// serial unit side
	output base_clock_pkg::unit_ctrl_t [1:0]    unit_ctrl,
	output logic      [1:0]                     base_tick,
	output logic      [1:0]                     baud_clk
);
	base_clock_pkg::bus_state_t         state_reg;
	base_clock_pkg::bus_state_t         state_next;
	logic [31:0]                        prdata_reg;
	logic                               pslverr_reg;
	logic [3:0]                         sel_reg [2];
	base_clock_pkg::unit_ctrl_t [1:0]   ctrl_reg;
	logic [7:0]                         div_reg [2];
	logic [1:0]                         base_tick_reg;
	logic                               timer_prev_reg;
	logic                               timer_rise;
	logic [base_clock_pkg::PRESCALE_W-1:0] pcount;
	logic [base_clock_pkg::PRESCALE_W:0]   ptick;
	logic [1:0]                         counter_pulse;
	logic                               wr_en;
	logic [31:0]                        rdata;
	logic                               hit;

	// apb handshake: one wait-free access phase, answered from flops
	always_comb begin
		case (state_reg)
			base_clock_pkg::BUS_IDLE:
				state_next = (psel && !penable) ? base_clock_pkg::BUS_ANSWER
				                                : base_clock_pkg::BUS_IDLE;
			base_clock_pkg::BUS_ANSWER:
				state_next = base_clock_pkg::BUS_IDLE;
			default:
				state_next = base_clock_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= base_clock_pkg::BUS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign wr_en = (state_reg == base_clock_pkg::BUS_ANSWER) && psel && penable && pwrite;

	// read decode; unmapped addresses answer with an error and zero data
	always_comb begin
		hit   = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			base_clock_pkg::SEL0_ADDR:  rdata = {28'h0000000, sel_reg[0]};
			base_clock_pkg::SEL1_ADDR:  rdata = {28'h0000000, sel_reg[1]};
			base_clock_pkg::CTRL0_ADDR: rdata = {24'h000000, ctrl_reg[0], 5'h00};
			base_clock_pkg::CTRL1_ADDR: rdata = {24'h000000, ctrl_reg[1], 5'h00};
			base_clock_pkg::DIV0_ADDR:  rdata = {24'h000000, div_reg[0]};
			base_clock_pkg::DIV1_ADDR:  rdata = {24'h000000, div_reg[1]};
			base_clock_pkg::STAT_ADDR:  rdata = {28'h0000000, baud_clk, base_tick_reg};
			default:                    hit   = 1'b0;
		endcase
	end

	// read data captured in the setup cycle, stands through the access phase
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (state_next == base_clock_pkg::BUS_ANSWER) begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : rdata;
			pslverr_reg <= ~hit;
		end else begin
			pslverr_reg <= 1'b0;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = state_reg[1];
	assign pslverr = pslverr_reg;

	// companion timer edge; the pin enable of the timer plays no part
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_prev_reg <= 1'b0;
		end else begin
			timer_prev_reg <= timer_out;
		end
	end

	assign timer_rise = timer_out & ~timer_prev_reg;

	pow2_prescaler #(
		.STAGES (base_clock_pkg::PRESCALE_W)
	) u_prescaler (
		.clk   (clk),
		.rst   (rst),
		.count (pcount),
		.tick  (ptick)
	);

	for (genvar u = 0; u < 2; u++) begin : g_unit
		localparam logic [17:0] SEL_A  = (u == 0) ? base_clock_pkg::SEL0_ADDR
		                                          : base_clock_pkg::SEL1_ADDR;
		localparam logic [17:0] CTRL_A = (u == 0) ? base_clock_pkg::CTRL0_ADDR
		                                          : base_clock_pkg::CTRL1_ADDR;
		localparam logic [17:0] DIV_A  = (u == 0) ? base_clock_pkg::DIV0_ADDR
		                                          : base_clock_pkg::DIV1_ADDR;

		// whole-byte write; a changed code while powered is dropped to protect the link
		always_ff @(posedge clk) begin
			if (rst) begin
				sel_reg[u] <= base_clock_pkg::SEL_RESET;
			end else if (wr_en && paddr == SEL_A && (!ctrl_reg[u].power ||
			             pwdata[3:0] == sel_reg[u])) begin
				sel_reg[u] <= pwdata[base_clock_pkg::SEL_LSB +: base_clock_pkg::SEL_W];
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				ctrl_reg[u] <= base_clock_pkg::CTRL_RESET[7:5];
			end else if (wr_en && paddr == CTRL_A) begin
				ctrl_reg[u].power <= pwdata[base_clock_pkg::POWER_BIT];
				ctrl_reg[u].txe   <= pwdata[base_clock_pkg::TXE_BIT];
				ctrl_reg[u].rxe   <= pwdata[base_clock_pkg::RXE_BIT];
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				div_reg[u] <= base_clock_pkg::DIV_RESET;
			end else if (wr_en && paddr == DIV_A) begin
				div_reg[u] <= pwdata[7:0];
			end
		end

		// base clock as an enable pulse; prohibited codes give no pulse
		always_ff @(posedge clk) begin
			if (rst) begin
				base_tick_reg[u] <= 1'b0;
			end else if (sel_reg[u] <= base_clock_pkg::CODE_MAX_DIV) begin
				base_tick_reg[u] <= ptick[sel_reg[u]];
			end else if (sel_reg[u] == base_clock_pkg::CODE_TIMER) begin
				base_tick_reg[u] <= timer_rise;
			end else begin
				base_tick_reg[u] <= 1'b0;
			end
		end

		baud_counter u_baud (
			.clk           (clk),
			.rst           (rst),
			.enable        (ctrl_reg[u].power),
			.base_tick     (base_tick_reg[u]),
			.divisor       (div_reg[u]),
			.counter_pulse (counter_pulse[u]),
			.baud_clk      (baud_clk[u])
		);
	end

	assign unit_ctrl = ctrl_reg;
	assign base_tick = base_tick_reg;

	sequence s_half_rate;
		!base_tick_reg[0] ##1 base_tick_reg[0];
	endsequence

	// code must still stand one cycle on, or a legal rewrite would trip the rate check
	sequence s_sel_is_two;
		sel_reg[0] == 4'h1 && $past(sel_reg[0]) == 4'h1 && base_tick_reg[0]
		##1 sel_reg[0] == 4'h1;
	endsequence

	property p_half_rate;
		@(posedge clk) disable iff (rst)
		s_sel_is_two |-> s_half_rate;
	endproperty

	sequence s_open_write0;
		!ctrl_reg[0].power && wr_en && paddr == base_clock_pkg::SEL0_ADDR;
	endsequence

	sequence s_open_write1;
		!ctrl_reg[1].power && wr_en && paddr == base_clock_pkg::SEL1_ADDR;
	endsequence

	a_sel_reset_zero: assert property (@(posedge clk) rst |=>
		sel_reg[0] == 4'h0 && sel_reg[1] == 4'h0)
		else $error("select register not zero after reset");

	a_sel_upper_zero: assert property (@(posedge clk) disable iff (rst)
		state_reg == base_clock_pkg::BUS_ANSWER && !pwrite &&
		(paddr == base_clock_pkg::SEL0_ADDR || paddr == base_clock_pkg::SEL1_ADDR)
		|-> prdata[31:4] == 28'h0000000)
		else $error("select register upper bits not zero");

	a_powered_sel_hold: assert property (@(posedge clk) disable iff (rst)
		ctrl_reg[0].power && wr_en && paddr == base_clock_pkg::SEL0_ADDR
		|=> sel_reg[0] == $past(sel_reg[0]))
		else $error("select field changed while unit powered");

	a_div_two_rate: assert property (p_half_rate)
		else $error("divide by two base clock wrong rate");

	a_prohibited_silent: assert property (@(posedge clk) disable iff (rst)
		sel_reg[1] > base_clock_pkg::CODE_TIMER |=> !base_tick_reg[1])
		else $error("prohibited code produced a base clock");

	a_timer_route: assert property (@(posedge clk) disable iff (rst)
		sel_reg[0] == base_clock_pkg::CODE_TIMER && timer_out && !timer_prev_reg
		|=> base_tick_reg[0])
		else $error("timer edge did not reach base clock");

	a_baud_half_rate: assert property (@(posedge clk) disable iff (rst)
		counter_pulse[0] |-> baud_clk[0] != $past(baud_clk[0]))
		else $error("baud clock did not toggle on counter output");

	a_prescale_free: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) |-> pcount == $past(pcount) + 10'h001)
		else $error("prescaler did not advance");

	a_sel1_powered_hold: assert property (@(posedge clk) disable iff (rst)
		ctrl_reg[1].power && wr_en && paddr == base_clock_pkg::SEL1_ADDR
		|=> sel_reg[1] == $past(sel_reg[1]))
		else $error("unit one select changed while powered");

	a_sel_write_lands: assert property (@(posedge clk) disable iff (rst)
		s_open_write0
		|=> sel_reg[0] == $past(pwdata[3:0]))
		else $error("unit zero select write did not land");

	a_sel1_write_lands: assert property (@(posedge clk) disable iff (rst)
		s_open_write1
		|=> sel_reg[1] == $past(pwdata[3:0]))
		else $error("unit one select write did not land");

	a_code_zero_every: assert property (@(posedge clk) disable iff (rst)
		sel_reg[0] == 4'h0 |=> base_tick_reg[0])
		else $error("undivided base clock missed a cycle");

	a_code_ten_rate: assert property (@(posedge clk) disable iff (rst)
		sel_reg[1] == base_clock_pkg::CODE_MAX_DIV && $past(sel_reg[1]) == base_clock_pkg::CODE_MAX_DIV
		&& base_tick_reg[1] |-> pcount == 10'h000)
		else $error("divide by 1024 base clock off its wrap");

	a_unit0_prohibited_silent: assert property (@(posedge clk) disable iff (rst)
		sel_reg[0] > base_clock_pkg::CODE_TIMER |=> !base_tick_reg[0])
		else $error("prohibited code produced a base clock on unit zero");

	a_timer_quiet: assert property (@(posedge clk) disable iff (rst)
		sel_reg[0] == base_clock_pkg::CODE_TIMER && !(timer_out && !timer_prev_reg)
		|=> !base_tick_reg[0])
		else $error("base clock pulsed without a timer edge");

	a_timer_route1: assert property (@(posedge clk) disable iff (rst)
		sel_reg[1] == base_clock_pkg::CODE_TIMER && timer_out && !timer_prev_reg
		|=> base_tick_reg[1])
		else $error("timer edge did not reach unit one base clock");

	a_baud_off_low: assert property (@(posedge clk) disable iff (rst)
		!ctrl_reg[0].power |=> !baud_clk[0] && !counter_pulse[0])
		else $error("unit zero baud clock active while unpowered");

	a_baud1_off_low: assert property (@(posedge clk) disable iff (rst)
		!ctrl_reg[1].power |=> !baud_clk[1] && !counter_pulse[1])
		else $error("unit one baud clock active while unpowered");

	a_pulse_needs_tick: assert property (@(posedge clk) disable iff (rst)
		counter_pulse[0] |-> $past(base_tick_reg[0]))
		else $error("unit zero counter wrapped without a base tick");

	a_pulse1_needs_tick: assert property (@(posedge clk) disable iff (rst)
		counter_pulse[1] |-> $past(base_tick_reg[1]))
		else $error("unit one counter wrapped without a base tick");

endmodule // base_clock_select

// File: test/test_uart_base_clock_select.sv
`timescale 1ns/1ns
module test_uart_base_clock_select;
	logic                             clk;
	logic                             rst;
	logic                             psel;
	logic                             penable;
	logic                             pwrite;
	logic [17:0]                      paddr;
	logic [31:0]                      pwdata;
	logic [31:0]                      prdata;
	logic                             pready;
	logic                             pslverr;
	logic                             timer_out;
	base_clock_pkg::unit_ctrl_t [1:0] unit_ctrl;
	logic [1:0]                       base_tick;
	logic [1:0]                       baud_clk;
	logic [2:0]                       tdiv;
	logic [31:0]                      rdv;
	logic                             errv;
	int                               miscompares;
	int                               n_tests;
	int                               cyc;
	int                               pulses;
	int                               toggles;

	base_clock_select dut (
		.clk       (clk),
		.rst       (rst),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.timer_out (timer_out),
		.unit_ctrl (unit_ctrl),
		.base_tick (base_tick),
		.baud_clk  (baud_clk)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// timer already running, even duty: one rise every 16 cycles
	always @(posedge clk) begin
		tdiv <= tdiv + 3'h1;
		if (tdiv == 3'h3) begin
			timer_out <= ~timer_out;
		end
	end

	// whole run needs about 58k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// answer comes from flops: mid-cycle value is what the next edge samples
		do begin
			@(negedge clk);
			n++;
			done = (pready === 1'b1);
			rdv  = prdata;
			errv = pslverr;
			@(posedge clk);
		end while (!done && n < 50);
		if (!done) begin
			miscompares++;
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [17:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rdv, exp);
	endtask

	// counts base ticks and baud toggles of one unit, sampled mid-cycle
	task automatic measure(input int u, input int n);
		logic prev;
		repeat (4) @(posedge clk);
		pulses = 0;
		toggles = 0;
		@(negedge clk);
		prev = baud_clk[u];
		repeat (n) begin
			@(negedge clk);
			if (base_tick[u] === 1'b1) pulses++;
			if (baud_clk[u] !== prev) toggles++;
			prev = baud_clk[u];
		end
	endtask

	function automatic int exp_pulses(input int c);
		if (c <= 10) return 2048 >> c;
		if (c == 11) return 128;
		return 0;
	endfunction

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h00000;
		pwdata = 32'h0000_0000;
		timer_out = 1'b0;
		tdiv = 3'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(base_clock_pkg::SEL0_ADDR, 32'h0000_0000);
		rd(base_clock_pkg::SEL1_ADDR, 32'h0000_0000);
		rd(base_clock_pkg::DIV0_ADDR, 32'h0000_00FF);
		rd(base_clock_pkg::STAT_ADDR, 32'h0000_0003);
		end_test("reset");
		wr(base_clock_pkg::SEL0_ADDR, 32'hFFFF_FFF3);
		rd(base_clock_pkg::SEL0_ADDR, 32'h0000_0003);
		end_test("field");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(base_clock_pkg::SEL0_ADDR, 32'h0000_0000);
		end_test("second reset");
		// codes 0 to 12 on both units, prohibited code 12 gives nothing
		for (int u = 0; u < 2; u++) begin
			for (int c = 0; c < 13; c++) begin
				wr(u ? base_clock_pkg::SEL1_ADDR : base_clock_pkg::SEL0_ADDR, 32'(c));
				measure(u, 2048);
				check(32'(pulses), 32'(exp_pulses(c)));
			end
		end
		end_test("codes");
		wr(base_clock_pkg::DIV0_ADDR, 32'h0000_0004);
		wr(base_clock_pkg::SEL0_ADDR, 32'h0000_0002);
		wr(base_clock_pkg::CTRL0_ADDR, 32'h0000_00C0);
		@(negedge clk);
		check(32'(unit_ctrl[0]), 32'h0000_0006);
		rd(base_clock_pkg::CTRL0_ADDR, 32'h0000_00C0);
		wr(base_clock_pkg::SEL0_ADDR, 32'h0000_0005);
		rd(base_clock_pkg::SEL0_ADDR, 32'h0000_0002);
		wr(base_clock_pkg::SEL0_ADDR, 32'h0000_0002);
		rd(base_clock_pkg::SEL0_ADDR, 32'h0000_0002);
		measure(0, 2048);
		check(32'(pulses), 32'h0000_0200);
		check(32'(toggles), 32'h0000_0080);
		wr(base_clock_pkg::CTRL0_ADDR, 32'h0000_0000);
		measure(0, 64);
		check(32'(toggles), 32'h0000_0000);
		check(32'(baud_clk[0]), 32'h0);
		end_test("live");
		wr(base_clock_pkg::DIV1_ADDR, 32'h0000_0002);
		wr(base_clock_pkg::SEL1_ADDR, 32'h0000_0000);
		wr(base_clock_pkg::CTRL1_ADDR, 32'h0000_00A0);
		@(negedge clk);
		check(32'(unit_ctrl[1]), 32'h0000_0005);
		measure(1, 2048);
		check(32'(pulses), 32'h0000_0800);
		check(32'(toggles), 32'h0000_0200);
		wr(base_clock_pkg::CTRL1_ADDR, 32'h0000_0000);
		measure(1, 16);
		check(32'(toggles), 32'h0000_0000);
		check(32'(baud_clk[1]), 32'h0);
		end_test("unit one");
		apb(1'b0, 18'h00010, 32'h0000_0000);
		check(32'(errv), 32'h1);
		check(rdv, 32'h0000_0000);
		apb(1'b1, 18'h00010, 32'h0000_00AA);
		check(32'(errv), 32'h1);
		end_test("unmapped");
		test_done();
	end
endmodule // test_uart_base_clock_select
